// ---- wdr_consts.svh ----
// Constants for the runaway watchdog: counter reset value and timing counts.
// Assumes it is included by the package and the design file by bare name.
`ifndef WDR_CONSTS_SVH
`define WDR_CONSTS_SVH
`define WDR_CNT_WIDTH 16
`define WDR_CNT_INIT 16'hffff
`define WDR_RESTART_PERIOD 65534
`define WDR_RST_PULSE_CYCLES 4'h8
`endif

// ---- wdr_pkg.sv ----
// Types shared by the runaway watchdog.
// Assumes the constants header sits in the same folder.
`include "wdr_consts.svh"
package wdr_pkg;
  typedef struct packed {
    logic restart;
    logic disable_cmd;
    logic other;
  } wdr_instr_type;
  typedef struct packed {
    logic enable_flag;
    logic first_flag;
    logic second_flag;
  } wdr_flags_type;
endpackage

// ---- wdr_watchdog.sv ----
// Runaway watchdog: counter, enable and underflow flags, reset pin pull-down.
// Assumes instruction strobes are one-cycle pulses on clk, one per machine cycle at most.
`timescale 1ns/1ns
`include "wdr_consts.svh"
// Behaviour
// - Counter counts down from all ones per cycle
// - Underflow sets the first underflow flag
// - Underflow with first flag set and no restart asserts reset
// - Watchdog reset pulls reset pin low
// - Watchdog active while enable flag is one
// - Disable then restart clears enable flag
// - Disable alone leaves watchdog active
// - Enable set on reset and back-up entry
// - Restart clears first flag unless underflow sets it in the same tick, and skips if it was set
// - Skip works even when watchdog disabled
// - Back-up entry reinitialises first flag, counter
module wdr_watchdog #(
  parameter int CNT_WIDTH = `WDR_CNT_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction strobes from the core, one per machine cycle
  input wire logic cycle_tick,
  input wire wdr_pkg::wdr_instr_type instr,
  // RAM back-up mode entry pulse
  input wire logic backup_entry,
  // Status and skip request
  output wdr_pkg::wdr_flags_type flags,
  output logic skip_next,
  output logic [CNT_WIDTH-1:0] watchdog_counter,
  // Reset pin pull-down transistor
  output logic reset_pin_out,
  output logic reset_pin_oe
);
  localparam logic [CNT_WIDTH-1:0] CNT_INIT = CNT_WIDTH'(`WDR_CNT_INIT);
  localparam logic [CNT_WIDTH-1:0] CNT_ONE = CNT_WIDTH'(1);
  localparam logic [CNT_WIDTH:0] SPAN_ONE = (CNT_WIDTH + 1)'(1);
  localparam logic [3:0] PULSE_LEN = `WDR_RST_PULSE_CYCLES;

  logic [CNT_WIDTH-1:0] cnt_reg, cnt_next;
  logic en_reg, en_next, f1_reg, f1_next, f2_reg, f2_next;
  logic dis_pend_reg, dis_pend_next, skip_reg, skip_next_v;
  logic [3:0] pulse_reg, pulse_next;
  logic underflow;
  logic [CNT_WIDTH:0] span_reg, span_next;

  always_comb begin
    cnt_next = cnt_reg;
    en_next = en_reg;
    f1_next = f1_reg;
    f2_next = f2_reg;
    dis_pend_next = dis_pend_reg;
    skip_next_v = 1'b0;
    pulse_next = (pulse_reg != 4'h0) ? pulse_reg - 4'h1 : 4'h0;
    underflow = 1'b0;
    if (pulse_reg == 4'h1) begin
      // The pulse end acts as the system reset the pin produced.
      cnt_next = CNT_INIT;
      f1_next = 1'b0;
      f2_next = 1'b0;
      en_next = 1'b1;
      dis_pend_next = 1'b0;
    end else if (backup_entry) begin
      cnt_next = CNT_INIT;
      f1_next = 1'b0;
      en_next = 1'b1;
      dis_pend_next = 1'b0;
    end else if (cycle_tick && pulse_reg == 4'h0) begin
      cnt_next = cnt_reg - CNT_ONE;
      underflow = (cnt_reg == '0) && en_reg;
      if (instr.restart) begin
        skip_next_v = f1_reg;
        f1_next = 1'b0;
        if (dis_pend_reg) begin
          en_next = 1'b0;
        end
      end
      if (underflow) begin
        // Set wins over a restart in the same cycle.
        f1_next = 1'b1;
        if (f1_reg && !instr.restart) begin
          f2_next = 1'b1;
          pulse_next = PULSE_LEN;
        end
      end
      // Any other instruction in between cancels the pending disable.
      dis_pend_next = instr.disable_cmd;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= CNT_INIT;
      en_reg <= 1'b1;
      f1_reg <= 1'b0;
      f2_reg <= 1'b0;
      dis_pend_reg <= 1'b0;
      skip_reg <= 1'b0;
      pulse_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
      en_reg <= en_next;
      f1_reg <= f1_next;
      f2_reg <= f2_next;
      dis_pend_reg <= dis_pend_next;
      skip_reg <= skip_next_v;
      pulse_reg <= pulse_next;
    end
  end

  // Counts accepted ticks since the last restart or re-initialisation, saturating.
  // It lets the second-flag check see a full silent period without a long repetition.
  always_comb begin
    span_next = span_reg;
    if (pulse_reg == 4'h1 || backup_entry) begin
      span_next = '0;
    end else if (cycle_tick && pulse_reg == 4'h0) begin
      if (instr.restart) begin
        span_next = '0;
      end else if (span_reg != '1) begin
        span_next = span_reg + SPAN_ONE;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      span_reg <= '0;
    end else begin
      span_reg <= span_next;
    end
  end

  assign watchdog_counter = cnt_reg;
  assign flags = '{enable_flag: en_reg, first_flag: f1_reg, second_flag: f2_reg};
  assign skip_next = skip_reg;
  assign reset_pin_out = 1'b0;
  // Open drain: the pin is only ever pulled low, never driven high.
  assign reset_pin_oe = f2_reg;

  // Each check looks one edge after the tick that it judges, when the result has settled.
  // Antecedents leave out the reset pulse and back-up entry, which override any instruction.
  a_restart_skip: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && instr.restart && pulse_reg == 4'h0 && !backup_entry) |=>
    (skip_next == $past(f1_reg))) else $error("restart skip mismatch");

  a_skip_quiet: assert property (@(posedge clk) disable iff (rst)
    !(cycle_tick && instr.restart && pulse_reg == 4'h0 && !backup_entry) |=>
    !skip_next) else $error("skip raised without a restart");

  a_restart_clear: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && instr.restart && pulse_reg == 4'h0 && !backup_entry &&
    !(en_reg && cnt_reg == '0)) |=> !f1_reg) else $error("restart did not clear first flag");

  a_second_flag: assert property (@(posedge clk) disable iff (rst)
    $rose(f2_reg) |-> $past(f1_reg) && $past(cnt_reg) == '0 && $past(en_reg))
    else $error("second flag without double underflow");

  a_second_span: assert property (@(posedge clk) disable iff (rst)
    $rose(f2_reg) |-> span_reg[CNT_WIDTH])
    else $error("second flag before a full period without restart");

  a_pin_follows: assert property (@(posedge clk) disable iff (rst)
    $rose(f2_reg) |-> reset_pin_oe [*8] ##1 !reset_pin_oe)
    else $error("reset pin pulse length wrong");

  a_pulse_frozen: assert property (@(posedge clk) disable iff (rst)
    (pulse_reg > 4'h1 && !backup_entry) |=> cnt_reg == $past(cnt_reg) && f2_reg)
    else $error("watchdog moved during the reset pulse");

  a_first_flag: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && en_reg && cnt_reg == '0 && pulse_reg == 4'h0 && !backup_entry)
    |=> f1_reg) else $error("underflow did not set first flag");

  a_count_down: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && pulse_reg == 4'h0 && !backup_entry) |=>
    cnt_reg == $past(cnt_reg) - 1'b1) else $error("counter did not decrement");

  a_count_wrap: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && pulse_reg == 4'h0 && !backup_entry && cnt_reg == '0) |=>
    cnt_reg == CNT_INIT) else $error("counter did not wrap to all ones");

  a_disabled_quiet: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && !en_reg && !instr.restart && pulse_reg == 4'h0 && !backup_entry) |=>
    f1_reg == $past(f1_reg) && !f2_reg) else $error("disabled watchdog changed its flags");

  a_disable_seq: assert property (@(posedge clk) disable iff (rst)
    $fell(en_reg) |-> $past(dis_pend_reg) && $past(instr.restart))
    else $error("enable cleared without disable sequence");

  a_seq_enable: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && instr.restart && dis_pend_reg && pulse_reg == 4'h0 && !backup_entry) |=>
    !en_reg) else $error("disable sequence left the watchdog enabled");

  a_disable_alone: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && instr.disable_cmd && !instr.restart && pulse_reg == 4'h0 &&
    !backup_entry) |=> en_reg == $past(en_reg)) else $error("disable alone changed enable");

  a_enable_set: assert property (@(posedge clk) disable iff (rst)
    (backup_entry || pulse_reg == 4'h1) |=> en_reg)
    else $error("enable flag not set by back-up entry or reset");

  a_disable_skip: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && instr.restart && dis_pend_reg && f1_reg && pulse_reg == 4'h0 &&
    !backup_entry) |=> skip_next && !en_reg) else $error("skip lost on disabling restart");

  a_seq_adjacent: assert property (@(posedge clk) disable iff (rst)
    (cycle_tick && !instr.disable_cmd && pulse_reg == 4'h0 && !backup_entry) |=>
    !dis_pend_reg) else $error("pending disable outlived the next instruction");

  a_backup_init: assert property (@(posedge clk) disable iff (rst)
    (backup_entry && pulse_reg != 4'h1) |=> cnt_reg == CNT_INIT && !f1_reg && en_reg)
    else $error("back-up entry did not reinitialise");

  a_reset_clean: assert property (@(posedge clk) disable iff (rst)
    $fell(f2_reg) |-> cnt_reg == CNT_INIT && !f1_reg && en_reg)
    else $error("watchdog reset left stale state");
endmodule

// ---- wdr_core_model.sv ----
// Core model: one instruction strobe per random machine cycle.
// Assumes the watchdog samples strobes and its counter at the rising edge.
`timescale 1ns/1ns
module wdr_core_model #(parameter int CNT_WIDTH = 8) (
  // Clock, reset and behaviour select
  input wire logic clk,
  input wire logic rst,
  input wire logic runaway,
  input wire logic [CNT_WIDTH-1:0] watchdog_counter,
  // Instruction strobes
  output logic cycle_tick,
  output wdr_pkg::wdr_instr_type instr
);
  int r;
  always @(posedge clk or posedge rst) begin
    r = $urandom % 32;
    if (rst) begin
      cycle_tick <= 1'b0;
      instr <= 3'h1;
    end else begin
      cycle_tick <= (r % 2) == 0;
      // Outside runaway, restarts are random and forced near count zero, meeting each underflow.
      if (!runaway && (r < 2 || watchdog_counter[CNT_WIDTH-1:1] == '0)) instr <= 3'h4;
      else if (!runaway && r < 8) instr <= 3'h2;
      else instr <= 3'h1;
    end
  end
endmodule

// ---- tb_top.sv ----
// Bench: random core traffic and back-up entries against a cycle model.
// Assumes a shortened counter width; results land one clock after each strobe.
`timescale 1ns/1ns
module tb_top;
  localparam int CW = 8;
  logic clk = 1'b0, rst = 1'b1, runaway = 1'b0, backup_entry = 1'b0;
  logic cycle_tick, skip_next, reset_pin_out, reset_pin_oe, en, f1, f2, sk, pend;
  wdr_pkg::wdr_instr_type instr;
  wdr_pkg::wdr_flags_type flags;
  logic [CW-1:0] watchdog_counter, cnt;
  int n_fail = 0, n_checks = 0, cyc = 0, pl = 0;
  wdr_watchdog #(.CNT_WIDTH(CW)) wdr_watchdog_i (.clk(clk), .rst(rst),
    .cycle_tick(cycle_tick), .instr(instr), .backup_entry(backup_entry), .flags(flags),
    .skip_next(skip_next), .watchdog_counter(watchdog_counter),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe));
  wdr_core_model #(.CNT_WIDTH(CW)) wdr_core_model_i (.clk(clk), .rst(rst),
    .runaway(runaway), .watchdog_counter(watchdog_counter), .cycle_tick(cycle_tick),
    .instr(instr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // The end of the pin pulse acts as a full system reset.
  // Underflow looks at the enable flag as it stood before this tick's restart.
  always @(posedge clk or posedge rst) begin
    sk = 1'b0;
    if (rst || pl == 1) begin
      cnt = '1;
      {en, f1, f2, pend, pl} = {4'h8, 32'd0};
    end else begin
      if (pl > 1) pl--;
      if (backup_entry) {en, f1, pend, cnt} = {3'h4, {CW{1'b1}}};
      else if (cycle_tick && pl == 0) begin
        sk = instr.restart & f1;
        if (instr.restart) f1 = 1'b0;
        if (cnt != 0) cnt--;
        else begin
          cnt = '1;
          if (en && f1) {f2, pl} = {1'b1, 32'd8};
          else if (en) f1 = 1'b1;
        end
        if (instr.restart && pend) en = 1'b0;
        pend = instr.disable_cmd;
      end
    end
  end
  always @(negedge clk) if (!rst) begin
    chk(16'(watchdog_counter), 16'(cnt));
    chk(16'(flags), 16'({en, f1, f2}));
    chk(16'(skip_next), 16'(sk));
    chk(16'({reset_pin_oe, reset_pin_out}), 16'({pl != 0, 1'b0}));
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial forever #50 clk = ~clk;
  initial begin
    void'($urandom(32'h73e3));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6000) @(posedge clk) backup_entry <= ($urandom % 400) == 0;
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    @(posedge clk) {runaway, backup_entry} <= 2'h3;
    repeat (3000) @(posedge clk) backup_entry <= 1'b0;
    end_of_test();
  end
endmodule
